// File: logic/rtcsup_pkg.sv
package rtcsup_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned LOCKOUT_MS = 90;
  localparam int unsigned CONV_MS = 60;
  localparam int unsigned MAIN_PERIOD_S = 60;
  localparam int unsigned BAT_PERIOD_MIN = 10;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned MAIN_PERIOD_MS = MAIN_PERIOD_S * MS_PER_S;
  localparam int unsigned BAT_PERIOD_MS = BAT_PERIOD_MIN * S_PER_MIN * MS_PER_S;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TEMP = 8'h08;
  localparam logic [7:0] REG_TRIM = 8'h0c;
  localparam logic [7:0] REG_COEF = 8'h10;
  localparam logic [7:0] REG_CAL = 8'h14;
  localparam logic [7:0] REG_TS_DOWN = 8'h18;
  localparam logic [7:0] REG_TS_UP = 8'h1c;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_BOR_LSB = 1;
  localparam int unsigned CTRL_BAT_LSB = 4;
  localparam int unsigned CTRL_BATCOMP_BIT = 7;
  localparam int unsigned TRIM_COARSE_LSB = 8;
  localparam int unsigned COEF_HOT_LSB = 8;
  localparam int unsigned COEF_T0_LSB = 16;
  localparam int unsigned CAL_FINE_LSB = 8;
  localparam int unsigned CAL_COARSE_LSB = 16;
  localparam int unsigned CURVE_SHIFT = 10;
  localparam int unsigned STEP_SHIFT = 4;

  localparam logic [2:0] BOR_MAX = 3'h5;
  localparam logic [2:0] BAT_MAX = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned PIN_W = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CONV = 3'h1, ST_MUL = 3'h3, ST_SCALE = 3'h2, ST_COMMIT = 3'h6
  } rtcsup_fsm_t;

  typedef struct packed {
    logic awvalid; logic [7:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [7:0] araddr; logic rready;
  } rtcsup_axi_req_t;

  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } rtcsup_axi_rsp_t;

  typedef struct packed {
    logic main_below_trip; logic main_below_bat; logic main_above_1v;
    logic ramp_slow; logic bat_below_level; logic temp_done; logic [9:0] temp_code;
  } rtcsup_pins_t;

  typedef struct packed {
    logic [7:0] coef_cold; logic [7:0] coef_hot; logic [9:0] turnover_temperature;
    logic [4:0] trim_step_scale; logic [5:0] itr_fine; logic [7:0] itr_coarse;
  } rtcsup_trim_init_t;

  typedef struct packed {
    rtcsup_fsm_t fsm; logic loaded; logic on_backup; logic armed; logic lockout;
    logic [6:0] lock_cnt; logic [14:0] tick_cnt; logic [19:0] per_cnt; logic [6:0] conv_cnt;
    logic comp_en; logic bat_comp_en; logic [2:0] bor_sel; logic [2:0] bat_sel;
    rtcsup_trim_init_t cal; logic [9:0] temp; logic done_q; logic [27:0] work;
    logic [5:0] fine; logic [7:0] coarse;
    logic [31:0] ts_down; logic ts_down_vld; logic [31:0] ts_up;
    logic aw_held; logic [7:0] awaddr; logic w_held; logic [31:0] wdata; logic [3:0] wstrb;
    logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } rtcsup_state_t;

  localparam rtcsup_state_t STATE_RST = '0;
endpackage : rtcsup_pkg

// File: logic/rtcsup_sync.sv
module rtcsup_sync
  import rtcsup_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PIN_W-1:0] din,
  output logic [PIN_W-1:0] dout
);
  logic [PIN_W-1:0] meta;
  // First stage feeds only the second
  for (genvar i = 0; i < PIN_W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta[i] <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        meta[i] <= din[i];
        dout[i] <= meta[i];
      end
    end
  end
endmodule : rtcsup_sync

// File: logic/rtcsup_top.sv
module rtcsup_top
  import rtcsup_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES,
  parameter int unsigned MAIN_PER_MS = MAIN_PERIOD_MS,
  parameter int unsigned BAT_PER_MS = BAT_PERIOD_MS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire rtcsup_axi_req_t axi_req,
  output rtcsup_axi_rsp_t axi_rsp,
  input wire rtcsup_pins_t pins,
  input wire logic [31:0] rtc_time,
  input wire rtcsup_trim_init_t trim_init,
  output logic on_backup,
  output logic serial_en,
  output logic [2:0] brownout_trip_level,
  output logic [2:0] bat_level,
  output logic conv_req,
  output logic [5:0] final_fine_trim,
  output logic [7:0] final_coarse_trim
);
  rtcsup_state_t s;
  rtcsup_state_t next_s;
  rtcsup_pins_t sy;
  logic [PIN_W-1:0] sy_vec;
  logic ms_tick;
  logic sw_trig;
  logic per_trig;
  logic [19:0] per_lim;
  logic signed [10:0] delta;
  logic [9:0] mag;
  logic [7:0] coeff;
  logic [27:0] prod;
  logic [22:0] scaled;
  logic [13:0] itr_total;
  logic [31:0] merged;
  logic [31:0] rd_word;
  logic rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  rtcsup_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(pins),
    .dout(sy_vec)
  );
  assign sy = rtcsup_pins_t'(sy_vec);

  function automatic logic [31:0] reg_value(input rtcsup_state_t st, input rtcsup_pins_t p,
                                            input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    if (a == REG_CTRL) begin
      v[CTRL_EN_BIT] = st.comp_en;
      v[CTRL_BOR_LSB +: 3] = st.bor_sel;
      v[CTRL_BAT_LSB +: 3] = st.bat_sel;
      v[CTRL_BATCOMP_BIT] = st.bat_comp_en;
    end else if (a == REG_STATUS) begin
      v[4:0] = {st.fsm != ST_IDLE, st.armed, p.bat_below_level, st.lockout, st.on_backup};
    end else if (a == REG_TEMP) begin
      v[9:0] = st.temp;
    end else if (a == REG_TRIM) begin
      v[5:0] = st.fine;
      v[TRIM_COARSE_LSB +: 8] = st.coarse;
    end else if (a == REG_COEF) begin
      v[7:0] = st.cal.coef_cold;
      v[COEF_HOT_LSB +: 8] = st.cal.coef_hot;
      v[COEF_T0_LSB +: 10] = st.cal.turnover_temperature;
    end else if (a == REG_CAL) begin
      v[4:0] = st.cal.trim_step_scale;
      v[CAL_FINE_LSB +: 6] = st.cal.itr_fine;
      v[CAL_COARSE_LSB +: 8] = st.cal.itr_coarse;
    end else if (a == REG_TS_DOWN) begin
      v = st.ts_down;
    end else if (a == REG_TS_UP) begin
      v = st.ts_up;
    end
    return v;
  endfunction : reg_value

  function automatic logic addr_hit(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= REG_TS_UP;
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    sw_trig = 1'b0;
    per_trig = 1'b0;
    ms_tick = (s.tick_cnt == 15'(MS_CYC - 1));
    next_s.tick_cnt = ms_tick ? 15'h0 : s.tick_cnt + 15'h1;
    merged = '0;
    rd_word = '0;
    rd_ok = 1'b0;

    // Bus slave: address and data taken in either order
    if (axi_req.awvalid && !s.aw_held && !s.bvalid) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s.w_held && !s.bvalid) begin
      next_s.w_held = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = addr_hit(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      merged = reg_value(s, sy, s.awaddr);
      for (int b = 0; b < 4; b++) begin
        if (s.wstrb[b]) begin
          merged[8*b +: 8] = s.wdata[8*b +: 8];
        end
      end
      if (s.awaddr == REG_CTRL) begin
        next_s.comp_en = merged[CTRL_EN_BIT];
        sw_trig = merged[CTRL_EN_BIT];
        // Out-of-range level codes clamp to the top level
        next_s.bor_sel = (merged[CTRL_BOR_LSB +: 3] > BOR_MAX) ? BOR_MAX : merged[CTRL_BOR_LSB +: 3];
        next_s.bat_sel = (merged[CTRL_BAT_LSB +: 3] > BAT_MAX) ? BAT_MAX : merged[CTRL_BAT_LSB +: 3];
        next_s.bat_comp_en = merged[CTRL_BATCOMP_BIT];
      end else if (s.awaddr == REG_COEF) begin
        next_s.cal.coef_cold = merged[7:0];
        next_s.cal.coef_hot = merged[COEF_HOT_LSB +: 8];
        next_s.cal.turnover_temperature = merged[COEF_T0_LSB +: 10];
      end else if (s.awaddr == REG_CAL) begin
        next_s.cal.trim_step_scale = merged[4:0];
        next_s.cal.itr_fine = merged[CAL_FINE_LSB +: 6];
        next_s.cal.itr_coarse = merged[CAL_COARSE_LSB +: 8];
      end else if (s.awaddr == REG_TS_DOWN) begin
        next_s.ts_down_vld = 1'b0;
      end
    end
    if (axi_req.arvalid && !s.rvalid) begin
      rd_ok = addr_hit(axi_req.araddr);
      rd_word = rd_ok ? reg_value(s, sy, axi_req.araddr) : 32'h0;
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_word;
      next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end

    // Production trims recalled once after reset
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.cal = trim_init;
    end

    // Supply switchover; comparators carry the hysteresis
    if (!s.on_backup && sy.main_below_trip && sy.main_below_bat) begin
      next_s.on_backup = 1'b1;
      next_s.armed = sy.main_above_1v;
      next_s.lockout = 1'b0;
      if (!s.ts_down_vld) begin
        next_s.ts_down = rtc_time;
        next_s.ts_down_vld = 1'b1;
      end
    end else if (s.on_backup && !(sy.main_below_trip && sy.main_below_bat)) begin
      next_s.on_backup = 1'b0;
      next_s.ts_up = rtc_time;
      next_s.armed = 1'b0;
      if (s.armed && sy.ramp_slow) begin
        next_s.lockout = 1'b1;
        next_s.lock_cnt = 7'h0;
      end
    end else if (s.on_backup && !sy.main_above_1v) begin
      // A full collapse is a cold start, not a glitch
      next_s.armed = 1'b0;
    end
    if (s.lockout && ms_tick) begin
      next_s.lock_cnt = s.lock_cnt + 7'h1;
      if (s.lock_cnt == 7'(LOCKOUT_MS - 1)) begin
        next_s.lockout = 1'b0;
      end
    end

    // Conversion period: one minute on main, longer on backup
    per_lim = s.on_backup ? 20'(BAT_PER_MS - 1) : 20'(MAIN_PER_MS - 1);
    if (s.fsm == ST_IDLE && s.comp_en && (!s.on_backup || s.bat_comp_en) && ms_tick) begin
      if (s.per_cnt >= per_lim) begin
        next_s.per_cnt = 20'h0;
        per_trig = 1'b1;
      end else begin
        next_s.per_cnt = s.per_cnt + 20'h1;
      end
    end

    // Correction arithmetic from the temperature code alone
    delta = $signed({1'b0, s.temp}) - $signed({1'b0, s.cal.turnover_temperature});
    mag = delta[10] ? 10'(-delta) : 10'(delta);
    coeff = delta[10] ? s.cal.coef_cold : s.cal.coef_hot;
    // Widen before multiplying so the square keeps all its bits
    prod = 28'(mag) * 28'(mag) * 28'(coeff);
    scaled = 23'(s.work[27:CURVE_SHIFT]) * 23'(s.cal.trim_step_scale);
    itr_total = {s.cal.itr_coarse, s.cal.itr_fine};

    next_s.done_q = sy.temp_done;
    case (s.fsm)
      ST_IDLE: begin
        if (per_trig || sw_trig) begin
          next_s.fsm = ST_CONV;
          next_s.conv_cnt = 7'h0;
          // Period restarts at every conversion, also a software one
          next_s.per_cnt = 20'h0;
        end
      end
      ST_CONV: begin
        if (sy.temp_done && !s.done_q) begin
          next_s.temp = sy.temp_code;
        end
        if (ms_tick) begin
          next_s.conv_cnt = s.conv_cnt + 7'h1;
          if (s.conv_cnt == 7'(CONV_MS - 1)) begin
            next_s.fsm = ST_MUL;
          end
        end
      end
      ST_MUL: begin
        next_s.work = prod;
        next_s.fsm = ST_SCALE;
      end
      ST_SCALE: begin
        next_s.work = 28'(scaled >> STEP_SHIFT) + 28'(itr_total);
        next_s.fsm = ST_COMMIT;
      end
      ST_COMMIT: begin
        // Both halves move in one edge so the oscillator never sees a mix
        next_s.fine = s.work[5:0];
        next_s.coarse = s.work[13:6];
        next_s.fsm = ST_IDLE;
      end
      default: begin
        next_s.fsm = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign axi_rsp.awready = !s.aw_held && !s.bvalid;
  assign axi_rsp.wready = !s.w_held && !s.bvalid;
  assign axi_rsp.bvalid = s.bvalid;
  assign axi_rsp.bresp = s.bresp;
  assign axi_rsp.arready = !s.rvalid;
  assign axi_rsp.rvalid = s.rvalid;
  assign axi_rsp.rdata = s.rdata;
  assign axi_rsp.rresp = s.rresp;
  assign on_backup = s.on_backup;
  assign serial_en = s.loaded && !s.on_backup && !s.lockout;
  assign brownout_trip_level = s.bor_sel;
  assign bat_level = s.bat_sel;
  assign conv_req = (s.fsm == ST_CONV);
  assign final_fine_trim = s.fine;
  assign final_coarse_trim = s.coarse;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_calc;
    s.fsm == ST_MUL ##1 s.fsm == ST_SCALE ##1 s.fsm == ST_COMMIT;
  endsequence
  sequence seq_conv_end;
    s.fsm == ST_CONV && ms_tick && s.conv_cnt == 7'(CONV_MS - 1);
  endsequence

  chk_backup_entry: assert property (
    !s.on_backup && sy.main_below_trip && sy.main_below_bat |=> s.on_backup && !serial_en)
    else $error("backup not entered");
  chk_backup_exit: assert property (
    s.on_backup && !sy.main_below_trip |=> !s.on_backup ##0 s.ts_up == $past(rtc_time))
    else $error("backup exit or stamp wrong");
  chk_serial_off: assert property (
    s.on_backup || s.lockout |-> !serial_en)
    else $error("serial enabled in backup or lockout");
  chk_lock_len: assert property (
    s.lockout && ms_tick && s.lock_cnt == 7'(LOCKOUT_MS - 1) && !sy.main_below_trip |=> !s.lockout)
    else $error("lockout length wrong");
  chk_lock_cause: assert property (
    $rose(s.lockout) |-> $past(s.armed) && $past(sy.ramp_slow) && !s.on_backup)
    else $error("lockout without armed slow ramp");
  chk_ts_first: assert property (
    s.ts_down_vld && !(s.bvalid == 1'b0 && s.aw_held && s.w_held) |=> $stable(s.ts_down))
    else $error("first crossover stamp overwritten");
  chk_conv_calc: assert property (
    seq_conv_end |=> seq_calc ##1 s.fsm == ST_IDLE)
    else $error("conversion or calculation sequence broken");
  chk_pair_atomic: assert property (
    $changed({s.fine, s.coarse}) |-> $past(s.fsm) == ST_COMMIT)
    else $error("trim changed outside commit");
  chk_bor_range: assert property (
    s.bor_sel <= BOR_MAX && s.bat_sel <= BAT_MAX)
    else $error("level select out of range");
  chk_temp_read: assert property (
    axi_req.arvalid && axi_rsp.arready && axi_req.araddr == REG_TEMP
    |=> s.rvalid && s.rdata[9:0] == $past(s.temp) && s.rresp == RESP_OKAY)
    else $error("temperature read wrong");
  chk_load_init: assert property (
    !s.loaded |=> s.cal == $past(trim_init))
    else $error("production trims not loaded");
endmodule : rtcsup_top

// File: verif/rtcsup_env.sv
module rtcsup_env
  import rtcsup_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic conv_req,
  input wire logic [4:0] supply,
  input wire logic [9:0] temp_value,
  input wire logic slow,
  output rtcsup_pins_t pins
);
  logic [7:0] wait_cnt;
  logic done;
  ////////////////////////////////////////////////////////////
  // Sensor answers each conversion window once, promptly or late
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv_req) begin
      wait_cnt <= 8'h00;
      done <= 1'b0;
    end else if (wait_cnt == (slow ? 8'hc8 : 8'h04)) begin
      done <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 8'h01;
    end
  end
  // Code scrambled outside the result window so a stale capture shows up
  assign pins = {supply, done, (wait_cnt >= 8'h03) ? temp_value : ~temp_value};
endmodule : rtcsup_env

// File: verif/tb.sv
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb
  import rtcsup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn;
  rtcsup_axi_req_t axi_req;
  rtcsup_axi_rsp_t axi_rsp;
  rtcsup_pins_t pins;
  rtcsup_trim_init_t trim_init;
  logic [31:0] rtc_time;
  logic on_backup, serial_en, conv_req, slow;
  logic [2:0] brownout_trip_level, bat_level;
  logic [5:0] final_fine_trim;
  logic [7:0] final_coarse_trim;
  logic [4:0] supply;
  logic [9:0] temp_value;
  logic [31:0] lfsr = 32'h30d889b6;
  logic [31:0] rd;
  logic [1:0] r;
  int fail_count = 0;
  int checks_done = 0;
  int cold, hot, t0, sc, ifn, ico, n;
  always #20 aclk = ~aclk;
  rtcsup_top #(.MS_CYC(10), .MAIN_PER_MS(5), .BAT_PER_MS(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pins(pins), .rtc_time(rtc_time), .trim_init(trim_init),
    .on_backup(on_backup), .serial_en(serial_en), .brownout_trip_level(brownout_trip_level),
    .bat_level(bat_level), .conv_req(conv_req), .final_fine_trim(final_fine_trim),
    .final_coarse_trim(final_coarse_trim));
  rtcsup_env i_env (.aclk(aclk), .aresetn(aresetn), .conv_req(conv_req), .supply(supply),
    .temp_value(temp_value), .slow(slow), .pins(pins));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : next_rand
  function automatic logic [13:0] comp_model(input int t);
    longint d;
    longint w;
    d = t - t0;
    w = (d * d * ((d < 0) ? cold : hot)) >>> 10;
    w = ((w * sc) >>> 4) + ico * 64 + ifn;
    return 14'(w);
  endfunction : comp_model
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // Sampling at the falling edge sees exactly what the next rising edge takes
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw, got;
    int k;
    @(posedge aclk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    k = 0;
    do begin
      @(negedge aclk);
      ta = axi_req.awvalid && axi_rsp.awready;
      tw = axi_req.wvalid && axi_rsp.wready;
      got = axi_rsp.bvalid;
      resp = axi_rsp.bresp;
      k++;
      @(posedge aclk);
      if (ta) axi_req.awvalid <= 1'b0;
      if (tw) axi_req.wvalid <= 1'b0;
    end while (!got && k < 100);
    axi_req.bready <= 1'b0;
    if (!got) fail_count++;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ta, got;
    int k;
    @(posedge aclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    k = 0;
    do begin
      @(negedge aclk);
      ta = axi_req.arvalid && axi_rsp.arready;
      got = axi_rsp.rvalid;
      d = axi_rsp.rdata;
      resp = axi_rsp.rresp;
      k++;
      @(posedge aclk);
      if (ta) axi_req.arvalid <= 1'b0;
    end while (!got && k < 100);
    axi_req.rready <= 1'b0;
    if (!got) fail_count++;
  endtask : axi_rd
  task automatic wait_conv(input logic v);
    n = 0;
    while (conv_req !== v && n < 2000) begin
      @(negedge aclk);
      n++;
    end
  endtask : wait_conv
  task automatic conv_run(input int t, input logic sl);
    @(posedge aclk);
    temp_value <= 10'(t);
    slow <= sl;
    axi_wr(REG_CTRL, 32'h1, r);
    wait_conv(1'b1);
    wait_conv(1'b0);
    `CHK(n >= 590 && n <= 612, 1'b1)
    repeat (5) @(negedge aclk);
    axi_wr(REG_CTRL, 32'h0, r);
    `CHK({final_coarse_trim, final_fine_trim}, comp_model(t))
    axi_rd(REG_TRIM, rd, r);
    `CHK({rd[15:8], rd[5:0]}, comp_model(t))
    axi_rd(REG_TEMP, rd, r);
    `CHK(rd[9:0], 10'(t))
  endtask : conv_run
  // Backup trip, then return; lockout expected only for a live slow ramp
  task automatic outage(input logic a1v, input logic rs, input logic lock, input logic [31:0] tdn,
                        input logic [31:0] tup);
    @(posedge aclk);
    rtc_time <= tdn;
    supply <= {2'b11, a1v, rs, 1'b0};
    repeat (6) @(negedge aclk);
    `CHK(on_backup, 1'b1)
    `CHK(serial_en, 1'b0)
    @(posedge aclk);
    rtc_time <= tup;
    supply <= {3'b001, rs, 1'b0};
    repeat (6) @(negedge aclk);
    `CHK(on_backup, 1'b0)
    `CHK(serial_en, !lock)
    if (lock) begin
      repeat (850) @(negedge aclk);
      `CHK(serial_en, 1'b0)
      n = 0;
      while (!serial_en && n < 200) begin
        @(negedge aclk);
        n++;
      end
      `CHK(n <= 70, 1'b1)
    end
    @(posedge aclk);
    supply <= 5'b00100;
    axi_rd(REG_TS_UP, rd, r);
    `CHK(rd, tup)
  endtask : outage
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    finish_test();
  end
  initial begin
    logic [31:0] ta, tu;
    aresetn = 1'b0;
    axi_req = '0;
    rtc_time = 32'h0;
    supply = 5'b00100;
    temp_value = 10'h0;
    slow = 1'b0;
    trim_init = {8'h30, 8'h50, 10'h200, 5'h10, 6'h05, 8'h12};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(negedge aclk);
    `CHK(serial_en, 1'b1)
    `CHK({final_coarse_trim, final_fine_trim}, 14'h0)
    axi_rd(REG_CAL, rd, r);
    `CHK(rd, 32'h00120510)
    axi_rd(REG_COEF, rd, r);
    `CHK(rd, 32'h02005030)
    axi_rd(8'h20, rd, r);
    `CHK({r, rd}, {RESP_SLVERR, 32'h0})
    axi_wr(8'h06, 32'h1, r);
    `CHK(r, RESP_SLVERR)
    axi_wr(REG_TEMP, 32'h3ff, r);
    `CHK(r, RESP_OKAY)
    axi_rd(REG_TEMP, rd, r);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 8; i++) begin
      axi_wr(REG_CTRL, 32'(i * 18), r);
      repeat (2) @(negedge aclk);
      `CHK(brownout_trip_level, (i > 5) ? 3'h5 : 3'(i))
      `CHK(bat_level, (i > 6) ? 3'h6 : 3'(i))
    end
    $display("test registers done");
    axi_wr(REG_COEF, 32'h01f0443c, r);
    axi_wr(REG_CAL, 32'h00200a13, r);
    axi_rd(REG_COEF, rd, r);
    `CHK(rd, 32'h01f0443c)
    cold = 'h3c;
    hot = 'h44;
    t0 = 'h1f0;
    sc = 'h13;
    ifn = 'h0a;
    ico = 'h20;
    // First pass sits on the turnover point, the other two anywhere from 296 to 695
    for (int i = 0; i < 3; i++) begin
      conv_run((i == 0) ? t0 : 296 + int'(next_rand() % 400), i[0]);
    end
    $display("test compensation done");
    @(posedge aclk);
    temp_value <= 10'(t0);
    axi_wr(REG_CTRL, 32'h1, r);
    wait_conv(1'b1);
    wait_conv(1'b0);
    wait_conv(1'b1);
    `CHK(n >= 42 && n <= 56, 1'b1)
    axi_wr(REG_CTRL, 32'h0, r);
    wait_conv(1'b0);
    repeat (5) @(negedge aclk);
    `CHK({final_coarse_trim, final_fine_trim}, comp_model(t0))
    $display("test periodic done");
    @(posedge aclk);
    supply <= 5'b10100;
    repeat (6) @(negedge aclk);
    `CHK(on_backup, 1'b0)
    @(posedge aclk);
    supply <= 5'b00101;
    repeat (3) @(posedge aclk);
    axi_rd(REG_STATUS, rd, r);
    `CHK(rd[2:0], 3'b100)
    ta = next_rand();
    outage(1'b1, 1'b1, 1'b1, ta, next_rand());
    outage(1'b0, 1'b1, 1'b0, next_rand(), next_rand());
    tu = next_rand();
    outage(1'b1, 1'b0, 1'b0, next_rand(), tu);
    axi_rd(REG_TS_DOWN, rd, r);
    `CHK(rd, ta)
    axi_wr(REG_TS_DOWN, 32'h0, r);
    ta = next_rand();
    outage(1'b1, 1'b0, 1'b0, ta, next_rand());
    axi_rd(REG_TS_DOWN, rd, r);
    `CHK(rd, ta)
    $display("test supply done");
    finish_test();
  end
endmodule : tb
